// ---- core/pdx_pkg.sv ----
// constants and types for the sleep-pulse / crossover configuration block
package pdx_pkg;
	// ----------------------------------------
	// clock and time base
	// ----------------------------------------
	localparam int CLK_HZ = 250_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int PRE_W = 18;
	localparam int MS_W = 10;
	localparam int XO_W = 13;
	localparam logic [1:0] LOAD_WAIT = 2'h3;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_BASIC = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h10;
	localparam logic [7:0] ADDR_MODE = 8'h14;
	localparam logic [7:0] ADDR_STAT = 8'h18;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CFG_TX_EN = 15;
	localparam int CFG_TX_IVL = 13;
	localparam int CFG_WAKE1 = 12;
	localparam int CFG_GAP = 10;
	localparam int CFG_INDEP = 3;
	localparam int CFG_LPI = 2;
	localparam int CFG_XO_SLEEP = 1;
	localparam int CFG_XO_MAN = 0;
	localparam int BASIC_SRST = 15;
	localparam int BASIC_AN = 12;
	localparam int MODE_SLEEP_EN = 13;
	localparam int STAT_ASLEEP = 0;
	localparam int STAT_TX = 1;
	localparam int STAT_ARMED = 2;
	localparam int STAT_XO = 16;

	// ----------------------------------------
	// intervals in milliseconds, and the crossover sample count
	// ----------------------------------------
	localparam logic [MS_W-1:0] TX_IVL_0_MS = 10'd1000;
	localparam logic [MS_W-1:0] TX_IVL_1_MS = 10'd768;
	localparam logic [MS_W-1:0] TX_IVL_2_MS = 10'd512;
	localparam logic [MS_W-1:0] TX_IVL_3_MS = 10'd256;
	localparam logic [MS_W-1:0] GAP_0_MS = 10'd64;
	localparam logic [MS_W-1:0] GAP_1_MS = 10'd256;
	localparam logic [MS_W-1:0] GAP_2_MS = 10'd512;
	localparam logic [MS_W-1:0] GAP_3_MS = 10'd1000;
	localparam logic [XO_W-1:0] XO_SLEEP_MS = 13'd2976;
	localparam logic [XO_W-1:0] XO_SAMPLES = 13'd32;
	localparam logic [XO_W-1:0] XO_SAMPLE_MS = 13'd62;
	localparam logic [XO_W-1:0] XO_MAN_MS = 13'(XO_SAMPLES * XO_SAMPLE_MS);

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic tx_en;
		logic [1:0] tx_ivl;
		logic wake1;
		logic [1:0] gap;
		logic indep;
		logic lpi;
		logic xo_sleep;
		logic xo_man;
	} pdx_cfg_t;

	typedef struct packed {
		logic sleep_en;
		logic lpi_en;
		logic [XO_W-1:0] xover_ms;
	} pdx_ctl_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h1,
		RX_LISTEN = 3'h2,
		RX_ARMED = 3'h4
	} pdx_rx_e;

	localparam pdx_cfg_t CFG_RST = '{1'b0, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1};
	localparam logic AN_RST = 1'b1;
	localparam logic SLEEP_EN_RST = 1'b0;
endpackage

// ---- core/pdx_core.sv ----
// sleep link-pulse, low-power-idle and crossover configuration for one port
`timescale 1ns/1ps
module pdx_core #(
	parameter int CYC_PER_MS = pdx_pkg::CYC_PER_MS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// port state from the phy core
	input wire logic sleep_state_i,
	input wire logic peer_sleep_state_i,
	// pins: received link pulse and straps
	input wire logic nlp_rx_i,
	input wire logic fiber_mode_i,
	input wire logic lpi_strap_i,
	// controls out
	output logic nlp_tx_o,
	output logic wake_o,
	output logic port_soft_reset_o,
	output logic autoneg_enable_o,
	output pdx_pkg::pdx_ctl_t ctl_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		pdx_pkg::pdx_cfg_t cfg;
		logic sleep_en;
		logic an_en;
		logic srst;
		logic ack;
		logic [31:0] dat;
		logic [1:0] fib_sync;
		logic [1:0] strap_sync;
		logic [2:0] rx_sync;
		logic [1:0] load_cnt;
		logic loaded;
		logic [pdx_pkg::PRE_W-1:0] pre;
		logic [pdx_pkg::MS_W-1:0] tx_ms;
		logic [pdx_pkg::MS_W-1:0] rx_ms;
		pdx_pkg::pdx_rx_e rx_st;
		logic nlp_tx;
		logic wake;
		logic [pdx_pkg::XO_W-1:0] xover;
	} pdx_state_t;

	localparam pdx_state_t ST_RST = '{
		cfg: pdx_pkg::CFG_RST,
		sleep_en: pdx_pkg::SLEEP_EN_RST,
		an_en: pdx_pkg::AN_RST,
		rx_st: pdx_pkg::RX_IDLE,
		default: '0
	};
	localparam logic [pdx_pkg::PRE_W-1:0] PRE_LAST = pdx_pkg::PRE_W'(CYC_PER_MS - 1);

	pdx_state_t s;
	pdx_state_t next_s;
	logic tick;
	logic asleep;
	logic tx_ok;
	logic rx_edge;
	logic req;
	logic [7:0] addr;

	// ----------------------------------------
	// decoders
	// ----------------------------------------
	// pulse period for the tx interval field
	function automatic logic [pdx_pkg::MS_W-1:0] tx_ivl_ms(input logic [1:0] sel);
		case (sel)
			2'h0: tx_ivl_ms = pdx_pkg::TX_IVL_0_MS;
			2'h1: tx_ivl_ms = pdx_pkg::TX_IVL_1_MS;
			2'h2: tx_ivl_ms = pdx_pkg::TX_IVL_2_MS;
			default: tx_ivl_ms = pdx_pkg::TX_IVL_3_MS;
		endcase
	endfunction

	// longest accepted spacing of two received pulses
	function automatic logic [pdx_pkg::MS_W-1:0] gap_ms(input logic [1:0] sel);
		case (sel)
			2'h0: gap_ms = pdx_pkg::GAP_0_MS;
			2'h1: gap_ms = pdx_pkg::GAP_1_MS;
			2'h2: gap_ms = pdx_pkg::GAP_2_MS;
			default: gap_ms = pdx_pkg::GAP_3_MS;
		endcase
	endfunction

	// read image of the config register
	function automatic logic [31:0] cfg_image(input pdx_pkg::pdx_cfg_t c);
		logic [31:0] v;
		v = '0; // reserved bits stay zero
		v[pdx_pkg::CFG_TX_EN] = c.tx_en;
		v[pdx_pkg::CFG_TX_IVL +: 2] = c.tx_ivl;
		v[pdx_pkg::CFG_WAKE1] = c.wake1;
		v[pdx_pkg::CFG_GAP +: 2] = c.gap;
		v[pdx_pkg::CFG_INDEP] = c.indep;
		v[pdx_pkg::CFG_LPI] = c.lpi;
		v[pdx_pkg::CFG_XO_SLEEP] = c.xo_sleep;
		v[pdx_pkg::CFG_XO_MAN] = c.xo_man;
		cfg_image = v;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// all behaviour is computed here and registered below
	always_comb begin
		next_s = s;
		next_s.ack = 1'b0;
		next_s.nlp_tx = 1'b0;
		next_s.wake = 1'b0;
		next_s.srst = 1'b0;

		// pin synchronisers; the first flop feeds only the second
		next_s.fib_sync = {s.fib_sync[0], fiber_mode_i};
		next_s.strap_sync = {s.strap_sync[0], lpi_strap_i};
		next_s.rx_sync = {s.rx_sync[1:0], nlp_rx_i};
		rx_edge = s.rx_sync[1] & ~s.rx_sync[2];

		// straps are caught once the synchronisers have settled after reset
		if (!s.loaded) begin
			if (s.load_cnt == pdx_pkg::LOAD_WAIT) begin
				next_s.loaded = 1'b1;
				next_s.cfg.lpi = s.fib_sync[1] ? 1'b0 : s.strap_sync[1];
			end else begin
				next_s.load_cnt = s.load_cnt + 2'h1;
			end
		end

		// millisecond time base keeps the long timers narrow
		tick = (s.pre == PRE_LAST);
		next_s.pre = tick ? '0 : s.pre + 1'b1;

		// transmit side: pulse only while this port (and peer unless independent) sleeps
		asleep = s.sleep_en & sleep_state_i;
		tx_ok = s.cfg.tx_en & asleep & (s.cfg.indep | peer_sleep_state_i);
		if (!tx_ok) begin
			next_s.tx_ms = '0;
		end else if (tick) begin
			if (s.tx_ms == tx_ivl_ms(s.cfg.tx_ivl) - 1'b1) begin
				next_s.tx_ms = '0;
				next_s.nlp_tx = 1'b1;
			end else begin
				next_s.tx_ms = s.tx_ms + 1'b1;
			end
		end

		// receive side: wake detector
		case (s.rx_st)
			pdx_pkg::RX_IDLE: begin
				if (asleep) begin
					next_s.rx_st = pdx_pkg::RX_LISTEN;
				end
			end
			pdx_pkg::RX_LISTEN: begin
				if (!asleep) begin
					next_s.rx_st = pdx_pkg::RX_IDLE;
				end else if (rx_edge) begin
					if (s.cfg.wake1) begin
						next_s.wake = 1'b1;
					end else begin
						next_s.rx_st = pdx_pkg::RX_ARMED;
						next_s.rx_ms = '0;
					end
				end
			end
			pdx_pkg::RX_ARMED: begin
				if (!asleep) begin
					next_s.rx_st = pdx_pkg::RX_IDLE;
				end else if (rx_edge) begin
					next_s.wake = 1'b1;
					next_s.rx_st = pdx_pkg::RX_LISTEN;
				end else if (tick) begin
					// gap ran out: the next pulse counts as a first one again
					if (s.rx_ms == gap_ms(s.cfg.gap) - 1'b1) begin
						next_s.rx_st = pdx_pkg::RX_LISTEN;
					end else begin
						next_s.rx_ms = s.rx_ms + 1'b1;
					end
				end
			end
			default: begin
				next_s.rx_st = pdx_pkg::RX_IDLE;
			end
		endcase

		// crossover extension in milliseconds, the sum of both terms
		next_s.xover = '0;
		if (s.sleep_en & s.cfg.xo_sleep) begin
			next_s.xover = pdx_pkg::XO_SLEEP_MS;
		end
		if (!s.an_en & s.cfg.xo_man) begin
			next_s.xover = next_s.xover + pdx_pkg::XO_MAN_MS;
		end

		// soft reset restarts the wake and pulse machinery and sets autoneg enable back on, but keeps the config
		if (s.srst) begin
			next_s.rx_st = pdx_pkg::RX_IDLE;
			next_s.tx_ms = '0;
			next_s.an_en = pdx_pkg::AN_RST;
		end

		// bus slave: one wait state, unmapped reads return zero, writes dropped
		req = wb_cyc_i & wb_stb_i & ~s.ack;
		addr = {wb_adr_i[7:2], 2'h0};
		if (req) begin
			next_s.ack = 1'b1;
			next_s.dat = '0;
			case (addr)
				pdx_pkg::ADDR_CFG: begin
					next_s.dat = cfg_image(s.cfg);
					if (wb_we_i & wb_sel_i[1]) begin
						next_s.cfg.tx_en = wb_dat_i[pdx_pkg::CFG_TX_EN];
						next_s.cfg.tx_ivl = wb_dat_i[pdx_pkg::CFG_TX_IVL +: 2];
						next_s.cfg.wake1 = wb_dat_i[pdx_pkg::CFG_WAKE1];
						next_s.cfg.gap = wb_dat_i[pdx_pkg::CFG_GAP +: 2];
					end
					if (wb_we_i & wb_sel_i[0]) begin
						next_s.cfg.indep = wb_dat_i[pdx_pkg::CFG_INDEP];
						next_s.cfg.lpi = wb_dat_i[pdx_pkg::CFG_LPI];
						next_s.cfg.xo_sleep = wb_dat_i[pdx_pkg::CFG_XO_SLEEP];
						next_s.cfg.xo_man = wb_dat_i[pdx_pkg::CFG_XO_MAN];
					end
				end
				pdx_pkg::ADDR_BASIC: begin
					next_s.dat[pdx_pkg::BASIC_AN] = s.an_en;
					if (wb_we_i & wb_sel_i[1]) begin
						next_s.an_en = wb_dat_i[pdx_pkg::BASIC_AN];
						next_s.srst = wb_dat_i[pdx_pkg::BASIC_SRST];
					end
				end
				pdx_pkg::ADDR_MODE: begin
					next_s.dat[pdx_pkg::MODE_SLEEP_EN] = s.sleep_en;
					if (wb_we_i & wb_sel_i[1]) begin
						next_s.sleep_en = wb_dat_i[pdx_pkg::MODE_SLEEP_EN];
					end
				end
				pdx_pkg::ADDR_STAT: begin
					next_s.dat[pdx_pkg::STAT_ASLEEP] = asleep;
					next_s.dat[pdx_pkg::STAT_TX] = tx_ok;
					next_s.dat[pdx_pkg::STAT_ARMED] = (s.rx_st == pdx_pkg::RX_ARMED);
					next_s.dat[pdx_pkg::STAT_XO +: pdx_pkg::XO_W] = s.xover;
				end
				default: begin
					next_s.dat = '0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// rst_i is the chip-level phy reset; soft reset never reaches here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= ST_RST;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// every output is a field of the state register
	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign nlp_tx_o = s.nlp_tx;
	assign wake_o = s.wake;
	assign port_soft_reset_o = s.srst;
	assign autoneg_enable_o = s.an_en;
	assign ctl_o.sleep_en = s.sleep_en;
	assign ctl_o.lpi_en = s.cfg.lpi;
	assign ctl_o.xover_ms = s.xover;

endmodule

// ---- bench/pdx_core_properties.sv ----
// port assertions for the sleep-pulse and crossover block
`timescale 1ns/1ps
module pdx_core_properties #(
	parameter int CYC_PER_MS = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// watched ports
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic sleep_state_i,
	input wire logic nlp_tx_o,
	input wire logic wake_o,
	input wire logic autoneg_enable_o,
	input wire pdx_pkg::pdx_ctl_t ctl_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// the bus answers one cycle after it takes a request
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack late");
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	// the pulse is registered from the previous cycle's sleep enable and sleep state
	tx_needs_sleep_a: assert property (nlp_tx_o |-> $past(ctl_o.sleep_en) && $past(sleep_state_i))
		else $error("pulse sent while awake");
	tx_single_a: assert property (nlp_tx_o |=> !nlp_tx_o [*8]) else $error("pulses too close");
	wake_needs_sleep_a: assert property (wake_o |-> $past(ctl_o.sleep_en) && $past(sleep_state_i))
		else $error("wake while awake");
	wake_single_a: assert property (wake_o |=> !wake_o) else $error("wake too long");
	// only the documented extension sums can appear
	xover_legal_a: assert property (ctl_o.xover_ms inside {13'h0, 13'h7c0, 13'hba0, 13'h1360})
		else $error("bad crossover sum");
	xover_autoneg_a: assert property ((autoneg_enable_o && !ctl_o.sleep_en) [*3] |->
		ctl_o.xover_ms == 13'h0) else $error("manual extension with autoneg");
	xover_sleep_a: assert property ((!ctl_o.sleep_en) [*3] |-> ctl_o.xover_ms < 13'hba0)
		else $error("sleep extension without sleep");
endmodule
bind pdx_core pdx_core_properties #(.CYC_PER_MS(CYC_PER_MS)) u_props (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.sleep_state_i(sleep_state_i), .nlp_tx_o(nlp_tx_o), .wake_o(wake_o),
	.autoneg_enable_o(autoneg_enable_o), .ctl_o(ctl_o));

// ---- bench/pdx_link_partner.sv ----
// remote link partner that puts link pulses on the line
`timescale 1ns/1ps
module pdx_link_partner (
	// clock and request
	input wire logic clk_i,
	input wire logic send_i,
	// line
	output logic nlp_o
);
	logic [1:0] left = 2'h0;
	// one pulse three clocks wide per request; the line idles low between pulses
	always @(posedge clk_i) begin
		if (send_i) left <= 2'h3;
		else if (left != 2'h0) left <= left - 2'h1;
	end
	assign nlp_o = (left != 2'h0);
endmodule

// ---- bench/tb_pdx_core.sv ----
// self-checking bench for the sleep-pulse and crossover block
`timescale 1ns/1ps
module tb_pdx_core;
	localparam int CPM = 4;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic sleep_state_i = 1'b0, peer_sleep_state_i = 1'b0, fiber_mode_i = 1'b0;
	logic lpi_strap_i = 1'b1, send = 1'b0, nlp_rx_i, wb_ack_o, nlp_tx_o, wake_o;
	logic port_soft_reset_o, autoneg_enable_o;
	pdx_pkg::pdx_ctl_t ctl_o;
	int miscompares = 0, samples_checked = 0, srst_n = 0;
	int ivl [4] = '{1000, 768, 512, 256};
	int gms [4] = '{64, 256, 512, 1000};
	// 250 MHz
	always #2 clk_i = ~clk_i;
	pdx_core #(.CYC_PER_MS(CPM)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sleep_state_i(sleep_state_i), .peer_sleep_state_i(peer_sleep_state_i),
		.nlp_rx_i(nlp_rx_i), .fiber_mode_i(fiber_mode_i), .lpi_strap_i(lpi_strap_i),
		.nlp_tx_o(nlp_tx_o), .wake_o(wake_o), .port_soft_reset_o(port_soft_reset_o),
		.autoneg_enable_o(autoneg_enable_o), .ctl_o(ctl_o));
	pdx_link_partner u_peer (.clk_i(clk_i), .send_i(send), .nlp_o(nlp_rx_i));
	// count soft-reset strobes so the pulse itself is checked, not only its effect
	always @(posedge clk_i) if (port_soft_reset_o === 1'b1) srst_n++;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task tally_and_finish;
		if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// classic cycle, held until ack is sampled high
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	// write then compare lpi enable and crossover sum
	task xo(input logic [7:0] a, input logic [31:0] d, input logic [13:0] exp);
		wb(1'b1, a, d);
		repeat (2) @(posedge clk_i);
		check(32'({ctl_o.lpi_en, ctl_o.xover_ms}), 32'(exp));
	endtask
	// spacing of two successive sent pulses, bounded
	task tx_period(input int exp);
		int n;
		n = 0;
		while (nlp_tx_o !== 1'b1 && n < 5000) begin
			@(posedge clk_i);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (nlp_tx_o !== 1'b1 && n < 5000);
		check(32'(n), 32'(exp));
	endtask
	task quiet(input int len);
		int c;
		c = 0;
		repeat (len) begin
			@(posedge clk_i);
			if (nlp_tx_o !== 1'b0) c++;
		end
		check(32'(c), 32'h0);
	endtask
	// partner pulse after gap cycles, then look for wake over eight cycles
	task pulse(input int gap, input logic exp);
		logic seen;
		repeat (gap) @(posedge clk_i);
		send <= 1'b1;
		@(posedge clk_i);
		send <= 1'b0;
		seen = 1'b0;
		repeat (8) begin
			@(posedge clk_i);
			if (wake_o === 1'b1) seen = 1'b1;
		end
		check(32'(seen), 32'(exp));
	endtask
	task rearm;
		sleep_state_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		sleep_state_i <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		rd_chk(pdx_pkg::ADDR_CFG, 32'h5);
		wb(1'b1, pdx_pkg::ADDR_CFG, 32'hffff);
		rd_chk(pdx_pkg::ADDR_CFG, 32'hfc0f);
		rd_chk(8'h0c, 32'h0);
		xo(pdx_pkg::ADDR_CFG, 32'h1, 14'h0);
		xo(pdx_pkg::ADDR_BASIC, 32'h0, 14'h7c0);
		xo(pdx_pkg::ADDR_CFG, 32'h4, 14'h2000);
		xo(pdx_pkg::ADDR_MODE, 32'h2000, 14'h2000);
		xo(pdx_pkg::ADDR_CFG, 32'h3, 14'h1360);
		xo(pdx_pkg::ADDR_CFG, 32'h2, 14'hba0);
		xo(pdx_pkg::ADDR_MODE, 32'h0, 14'h0);
		wb(1'b1, pdx_pkg::ADDR_CFG, 32'h5);
		wb(1'b1, pdx_pkg::ADDR_BASIC, 32'h8000);
		rd_chk(pdx_pkg::ADDR_CFG, 32'h5);
		rd_chk(pdx_pkg::ADDR_BASIC, 32'h1000);
		check(32'(srst_n), 32'h1);
		check(32'(autoneg_enable_o), 32'h1);
		sleep_state_i <= 1'b1;
		wb(1'b1, pdx_pkg::ADDR_MODE, 32'h2000);
		rd_chk(pdx_pkg::ADDR_MODE, 32'h2000);
		check(32'(ctl_o.sleep_en), 32'h1);
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, pdx_pkg::ADDR_CFG, 32'h8008 | (k << 13));
			tx_period(ivl[k] * CPM);
		end
		wb(1'b1, pdx_pkg::ADDR_CFG, 32'he000);
		quiet(1100);
		peer_sleep_state_i <= 1'b1;
		tx_period(256 * CPM);
		rd_chk(pdx_pkg::ADDR_STAT, 32'h3);
		wb(1'b1, pdx_pkg::ADDR_MODE, 32'h0);
		quiet(1100);
		wb(1'b1, pdx_pkg::ADDR_MODE, 32'h2000);
		wb(1'b1, pdx_pkg::ADDR_CFG, 32'h1000);
		rearm();
		pulse(0, 1'b1);
		for (int g = 0; g < 4; g++) begin
			wb(1'b1, pdx_pkg::ADDR_CFG, 32'(g << 10));
			rearm();
			pulse(0, 1'b0);
			pulse(gms[g] * CPM - 16, 1'b1);
		end
		wb(1'b1, pdx_pkg::ADDR_CFG, 32'h0);
		rearm();
		pulse(0, 1'b0);
		rd_chk(pdx_pkg::ADDR_STAT, 32'h5);
		pulse(64 * CPM + 8, 1'b0);
		pulse(0, 1'b1);
		// second chip reset in mid-run, now strapped for fiber
		wb(1'b1, pdx_pkg::ADDR_BASIC, 32'h0);
		fiber_mode_i <= 1'b1;
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		rd_chk(pdx_pkg::ADDR_CFG, 32'h1);
		rd_chk(pdx_pkg::ADDR_MODE, 32'h0);
		rd_chk(pdx_pkg::ADDR_BASIC, 32'h1000);
		tally_and_finish();
	end
	// watchdog well past the expected run length
	initial begin
		#300000;
		miscompares++;
		tally_and_finish();
	end
endmodule
